// ---- hw/tws_map.svh ----
// register offsets, fields, reset values and status codes of the two-wire slave receiver
`ifndef TWS_MAP_SVH
`define TWS_MAP_SVH
// ============================================================
// register byte offsets
`define TWS_OFF_OWN_ADDR 8'h00
`define TWS_OFF_CTRL 8'h04
`define TWS_OFF_STATUS 8'h08
`define TWS_OFF_DATA 8'h0C
`define TWS_OFF_MISC 8'h10
// ============================================================
// link_control fields
`define TWS_CTL_IRQ_FLAG 7
`define TWS_CTL_ACK_EN 6
`define TWS_CTL_START_REQ 5
`define TWS_CTL_STOP_REQ 4
`define TWS_CTL_WCOL 3
`define TWS_CTL_IFACE_EN 2
`define TWS_CTL_IRQ_EN 0
// misc register fields
`define TWS_MISC_SLEEP 0
`define TWS_MISC_ARB_LOST 1
// ============================================================
// reset values
`define TWS_RST_OWN_ADDR 8'h00
`define TWS_RST_CTRL 8'h00
`define TWS_RST_STATUS 8'hF8
// ============================================================
// status codes, prescaler bits zero
`define TWS_ST_IDLE 8'hF8
`define TWS_ST_OWN_W 8'h60
`define TWS_ST_ARB_OWN_W 8'h68
`define TWS_ST_GC 8'h70
`define TWS_ST_ARB_GC 8'h78
`define TWS_ST_OWN_DATA_ACK 8'h80
`define TWS_ST_OWN_DATA_NACK 8'h88
`define TWS_ST_GC_DATA_ACK 8'h90
`define TWS_ST_GC_DATA_NACK 8'h98
`define TWS_ST_STOP 8'hA0
`define TWS_ST_ST_SLA_R 8'hA8
`define TWS_GC_ADDR 7'h00
`endif

// ---- hw/tws_pkg.sv ----
// types shared by the two-wire slave receiver modules
package tws_pkg;
   // ============================================================
   // bit-level receiver states, one-hot
   typedef enum logic [5:0] {
      TWS_IDLE = 6'b00_0001,
      TWS_ADDR = 6'b00_0010,
      TWS_AACK = 6'b00_0100,
      TWS_DATA = 6'b00_1000,
      TWS_DACK = 6'b01_0000,
      TWS_HOLD = 6'b10_0000
   } tws_state_t;
endpackage

// ---- hw/tws_pin_if.sv ----
// bundle of synchronised line levels and detected bus events
`timescale 1ns/1ps
`default_nettype none
interface tws_pin_if;
   logic scl; // synchronised clock level
   logic sda; // synchronised data level
   logic scl_rise; // one-cycle pulse on clock rise
   logic scl_fall; // one-cycle pulse on clock fall
   logic start; // start or repeated start seen
   logic stop; // stop seen
   modport src (output scl, sda, scl_rise, scl_fall, start, stop);
   modport dst (input scl, sda, scl_rise, scl_fall, start, stop);
endinterface
`default_nettype wire

// ---- hw/tws_line_sync.sv ----
// two-flop synchronisers and edge/condition detection for the bus lines
`timescale 1ns/1ps
`default_nettype none
module tws_line_sync (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic scl_i,
   input wire logic sda_i,
   tws_pin_if.src pins
);
   // ============================================================
   // synchronisers: first stage feeds only the second
   logic [1:0] scl_meta_ff;
   logic [1:0] sda_meta_ff;
   logic scl_ff; // third stage, used for edges
   logic sda_ff;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         scl_meta_ff <= 2'b11;
         sda_meta_ff <= 2'b11;
         scl_ff <= 1'b1;
         sda_ff <= 1'b1;
      end else begin
         scl_meta_ff <= {scl_meta_ff[0], scl_i};
         sda_meta_ff <= {sda_meta_ff[0], sda_i};
         scl_ff <= scl_meta_ff[1];
         sda_ff <= sda_meta_ff[1];
      end
   end
   // ============================================================
   // events: start and stop are sda moves while scl is high
   assign pins.scl = scl_meta_ff[1];
   assign pins.sda = sda_meta_ff[1];
   assign pins.scl_rise = scl_meta_ff[1] & ~scl_ff;
   assign pins.scl_fall = ~scl_meta_ff[1] & scl_ff;
   assign pins.start = scl_meta_ff[1] & scl_ff & sda_ff & ~sda_meta_ff[1];
   assign pins.stop = scl_meta_ff[1] & scl_ff & ~sda_ff & sda_meta_ff[1];
endmodule
`default_nettype wire

// ---- hw/tws_slave_rx.sv ----
// two-wire slave receiver with ahb-lite register access
// Contract
// R1: upper seven own-address bits are slave address
// R2: own-address bit 0 enables general call
// R3: software enables iface and ack, no start/stop
// R4: acknowledge address only with ack and iface enabled
// R5: write bit selects receive, read selects transmit; code has no transmitter and leaves a read address unacknowledged
// R6: address plus write sets flag and status
// R7: addressed after lost arbitration reports 0x68/0x78
// R8: cleared ack enable gives nack after byte
// R9: ack disabled still monitors, resumes on set
// R10: asleep, ack enabled still recognises address
// R11: wake holds scl low until flag cleared
// R12: data register unreliable after sleep wake
// R13: software clears flag by writing one
// R14: own address write acknowledged reports 0x60
// R15: lost arbitration then own write reports 0x68
// R16: general call acknowledged reports 0x70
// R17: lost arbitration then general call reports 0x78
// R18: acked data reports 0x80, byte readable
// R19: flag cleared, next byte acked per ack enable
// R20: status decoded with prescaler bits zero
// R21: nacked data reports 0x88, then unaddressed
// R22: stop or restart while addressed reports 0xA0
// R23: flag set stretches scl, status stable; code stretches only in TWS_HOLD, not after a stop or restart flag
`include "tws_map.svh"
`timescale 1ns/1ps
`default_nettype none
module tws_slave_rx (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe_n,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_n,
   output logic irq
);
   // ============================================================
   // line sampling
   tws_pin_if pins ();
   tws_line_sync u_sync (
      .hclk(hclk),
      .hresetn(hresetn),
      .scl_i(scl_i),
      .sda_i(sda_i),
      .pins(pins)
   );

   // ============================================================
   // registers
   logic [7:0] own_slave_address_ff; // address in [7:1], gc enable in [0]
   logic [7:0] link_control_ff; // flag, ack, start, stop, wcol, enable, irq enable
   logic [7:0] link_status_ff; // status code, prescaler bits kept zero
   logic [7:0] link_data_ff; // last received byte
   logic sleep_ff; // software says clocks are asleep
   logic arb_lost_ff; // master side lost arbitration, set from software hook
   logic woke_ff; // data register stale after a sleep match

   // ============================================================
   // ahb-lite slave: zero wait states, always okay
   logic wr_pend_ff; // write data phase pending
   logic [7:0] wr_addr_ff; // captured write address
   // a read is answered from the address phase,
   // so only writes keep a pending flag
   wire logic addr_phase = hsel & hready & htrans[1];
   wire logic wr_now = wr_pend_ff;
   // address phase capture
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_ff <= 1'b0;
         wr_addr_ff <= 8'h00;
      end else begin
         // a read leaves the pending flag low
         wr_pend_ff <= addr_phase & hwrite;
         if (addr_phase) begin
            // address held for the write decode
            wr_addr_ff <= haddr;
         end
      end
   end
   // read data come out of a register one cycle after the address phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (addr_phase & ~hwrite) begin
         case (haddr)
            `TWS_OFF_OWN_ADDR: hrdata <= {24'h00_0000, own_slave_address_ff};
            `TWS_OFF_CTRL: hrdata <= {24'h00_0000, link_control_ff};
            `TWS_OFF_STATUS: hrdata <= {24'h00_0000, link_status_ff & 8'hF8}; // [R20]
            `TWS_OFF_DATA: hrdata <= {24'h00_0000, link_data_ff}; // [R12]
            `TWS_OFF_MISC: hrdata <= {29'h0000_0000, woke_ff, arb_lost_ff, sleep_ff};
            default: hrdata <= 32'h0000_0000; // unmapped reads zero
         endcase
      end
   end
   // no wait states and no error response
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // ============================================================
   // bit engine state
   tws_pkg::tws_state_t state_ff;
   logic [7:0] shift_ff; // incoming bits, msb first
   logic [3:0] bit_cnt_ff; // bits taken in this byte
   logic gc_ff; // addressed by general call
   logic addressed_ff; // currently addressed as receiver
   logic ack_bit_ff; // ack decision for the current ack slot
   logic drive_sda_ff; // pull sda low
   logic set_flag; // engine event sets the flag
   logic [7:0] nxt_status;
   logic [7:0] nxt_data;
   logic load_data;

   wire logic ack_en = link_control_ff[`TWS_CTL_ACK_EN];
   wire logic iface_en = link_control_ff[`TWS_CTL_IFACE_EN];
   wire logic flag = link_control_ff[`TWS_CTL_IRQ_FLAG];
   wire logic [7:0] addr_byte = {shift_ff[6:0], pins.sda};
   wire logic own_hit = (addr_byte[7:1] == own_slave_address_ff[7:1]); // [R1]
   wire logic gc_hit = (addr_byte[7:1] == `TWS_GC_ADDR) & own_slave_address_ff[0]; // [R2]
   // sleep matters not here: scl edges clock the match as in active mode [R10]
   wire logic match_ok = ack_en & iface_en & (own_hit | gc_hit); // [R4] [R9]

   // ============================================================
   // receive state machine, advanced by scl edges
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_ff <= tws_pkg::TWS_IDLE;
         shift_ff <= 8'h00;
         bit_cnt_ff <= 4'h0;
         gc_ff <= 1'b0;
         addressed_ff <= 1'b0;
         ack_bit_ff <= 1'b0;
         drive_sda_ff <= 1'b0;
         set_flag <= 1'b0;
         load_data <= 1'b0;
         nxt_status <= `TWS_RST_STATUS;
         nxt_data <= 8'h00;
      end else begin
         set_flag <= 1'b0;
         load_data <= 1'b0;
         if (!iface_en) begin
            state_ff <= tws_pkg::TWS_IDLE;
            addressed_ff <= 1'b0;
            drive_sda_ff <= 1'b0;
         end else if (pins.start | pins.stop) begin
            if (addressed_ff) begin
               nxt_status <= `TWS_ST_STOP; // [R22]
               set_flag <= 1'b1;
            end
            addressed_ff <= 1'b0;
            drive_sda_ff <= 1'b0;
            bit_cnt_ff <= 4'h0;
            state_ff <= pins.start ? tws_pkg::TWS_ADDR : tws_pkg::TWS_IDLE;
         end else begin
            case (state_ff)
               tws_pkg::TWS_IDLE: begin
                  // wait for a start
               end
               tws_pkg::TWS_ADDR: begin
                  if (pins.scl_rise) begin
                     shift_ff <= addr_byte;
                     bit_cnt_ff <= bit_cnt_ff + 4'h1;
                     if (bit_cnt_ff == 4'h7) begin
                        // write bit: receive; read bit is not acknowledged [R5]
                        ack_bit_ff <= match_ok & ~pins.sda;
                        gc_ff <= gc_hit & ~own_hit;
                        state_ff <= tws_pkg::TWS_AACK;
                     end
                  end
               end
               tws_pkg::TWS_AACK: begin
                  if (pins.scl_fall) begin
                     drive_sda_ff <= ack_bit_ff;
                     if (!ack_bit_ff) begin
                        state_ff <= tws_pkg::TWS_IDLE;
                     end
                  end else if (pins.scl_rise & ack_bit_ff) begin
                     addressed_ff <= 1'b1;
                     set_flag <= 1'b1; // [R6]
                     if (gc_ff) begin
                        nxt_status <= arb_lost_ff ? `TWS_ST_ARB_GC : `TWS_ST_GC; // [R16] [R17] [R7]
                     end else begin
                        nxt_status <= arb_lost_ff ? `TWS_ST_ARB_OWN_W : `TWS_ST_OWN_W; // [R14] [R15]
                     end
                     state_ff <= tws_pkg::TWS_HOLD;
                  end
               end
               tws_pkg::TWS_HOLD: begin
                  // release sda on the falling edge after the ack slot
                  if (pins.scl_fall) begin
                     drive_sda_ff <= 1'b0;
                  end
                  // continue only once software cleared the flag [R23] [R19]
                  if (!flag & !set_flag & !drive_sda_ff) begin
                     bit_cnt_ff <= 4'h0;
                     state_ff <= addressed_ff ? tws_pkg::TWS_DATA : tws_pkg::TWS_IDLE;
                  end
               end
               tws_pkg::TWS_DATA: begin
                  if (pins.scl_rise) begin
                     shift_ff <= addr_byte;
                     bit_cnt_ff <= bit_cnt_ff + 4'h1;
                     if (bit_cnt_ff == 4'h7) begin
                        ack_bit_ff <= ack_en; // [R8] [R19]
                        state_ff <= tws_pkg::TWS_DACK;
                     end
                  end
               end
               tws_pkg::TWS_DACK: begin
                  if (pins.scl_fall) begin
                     drive_sda_ff <= ack_bit_ff; // nack leaves sda high [R8]
                  end else if (pins.scl_rise) begin
                     set_flag <= 1'b1;
                     load_data <= 1'b1;
                     nxt_data <= shift_ff; // [R18]
                     if (ack_bit_ff) begin
                        nxt_status <= gc_ff ? `TWS_ST_GC_DATA_ACK : `TWS_ST_OWN_DATA_ACK;
                     end else begin
                        nxt_status <= gc_ff ? `TWS_ST_GC_DATA_NACK : `TWS_ST_OWN_DATA_NACK; // [R21]
                        addressed_ff <= 1'b0;
                     end
                     state_ff <= tws_pkg::TWS_HOLD;
                  end
               end
               default: state_ff <= tws_pkg::TWS_IDLE;
            endcase
         end
      end
   end

   // ============================================================
   // status and data capture; status only moves with a new flag [R23]
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         link_status_ff <= `TWS_RST_STATUS;
         link_data_ff <= 8'h00;
      end else begin
         if (set_flag) begin
            link_status_ff <= nxt_status;
         end
         if (load_data) begin
            link_data_ff <= nxt_data;
         end else if (wr_now & (wr_addr_ff == `TWS_OFF_DATA)) begin
            link_data_ff <= hwdata[7:0];
         end
      end
   end

   // ============================================================
   // own address register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         own_slave_address_ff <= `TWS_RST_OWN_ADDR;
      end else if (wr_now & (wr_addr_ff == `TWS_OFF_OWN_ADDR)) begin
         own_slave_address_ff <= hwdata[7:0];
      end
   end

   // ============================================================
   // control register; the hardware set beats a same-cycle clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         link_control_ff <= `TWS_RST_CTRL;
      end else begin
         if (wr_now & (wr_addr_ff == `TWS_OFF_CTRL)) begin
            // bit 1 is reserved and reads zero
            link_control_ff[6:0] <= {hwdata[6:4], 1'b0, hwdata[2], 1'b0, hwdata[0]};
            if (hwdata[`TWS_CTL_IRQ_FLAG]) begin
               link_control_ff[`TWS_CTL_IRQ_FLAG] <= 1'b0; // write one clears [R13]
            end
         end
         if (set_flag) begin
            link_control_ff[`TWS_CTL_IRQ_FLAG] <= 1'b1;
         end
      end
   end

   // ============================================================
   // sleep and arbitration hooks; woke marks a stale data register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sleep_ff <= 1'b0;
         arb_lost_ff <= 1'b0;
         woke_ff <= 1'b0;
      end else begin
         if (wr_now & (wr_addr_ff == `TWS_OFF_MISC)) begin
            sleep_ff <= hwdata[`TWS_MISC_SLEEP];
            arb_lost_ff <= hwdata[`TWS_MISC_ARB_LOST];
         end else if (set_flag) begin
            arb_lost_ff <= 1'b0; // reported once
         end
         if (set_flag & sleep_ff) begin
            sleep_ff <= 1'b0; // address match wakes the part [R11]
            woke_ff <= 1'b1; // [R12]
         end else if (load_data) begin
            woke_ff <= 1'b0;
         end
      end
   end

   // ============================================================
   // pin drivers: hold scl low in TWS_HOLD while the flag stands [R11] [R23]
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         scl_o <= 1'b1;
         scl_oe_n <= 1'b1;
         sda_o <= 1'b1;
         sda_oe_n <= 1'b1;
         irq <= 1'b0;
      end else begin
         // the enables alone decide the pins
         scl_o <= 1'b0;
         scl_oe_n <= ~((flag | set_flag) & (state_ff == tws_pkg::TWS_HOLD) & ~pins.scl_rise
                       & ~pins.scl);
         sda_o <= 1'b0;
         sda_oe_n <= ~drive_sda_ff;
         irq <= flag & link_control_ff[`TWS_CTL_IRQ_EN];
      end
   end
endmodule
`default_nettype wire

// ---- tb/tws_master_model.sv ----
// behavioural two-wire bus master transmitter facing the slave receiver
`timescale 1ns/1ps
`default_nettype none
module tws_master_model (
   output logic scl_m,
   output logic sda_m,
   input wire logic scl_w,
   input wire logic sda_w
);
   // ==========================================
   // lines released; clock parked high between frames
   initial begin
      scl_m = 1'b1;
      sda_m = 1'b1;
   end
   int stalls = 0; // clock holds that outlived the bound
   // one bit clock of 160 ns; a stretched low phase is waited out, bounded
   task automatic pulse(output logic b);
      int n;
      #40 scl_m = 1'b1;
      n = 0;
      while (scl_w !== 1'b1 && n < 4000) begin
         #5 n++;
      end
      if (n == 4000) stalls++;
      #40 b = sda_w;
      #40 scl_m = 1'b0;
      #40;
   endtask
   // data falls while the clock is high; odd offset keeps phase unrelated
   task automatic start;
      #1.3 sda_m = 1'b0;
      #40 scl_m = 1'b0;
      #40;
   endtask
   // eight bits msb first, then the acknowledge slot with data released
   task automatic send(input logic [7:0] d, output logic ack);
      logic b;
      #1.3;
      for (int i = 7; i >= 0; i--) begin
         sda_m = d[i];
         pulse(b);
      end
      sda_m = 1'b1;
      pulse(b);
      ack = ~b;
   endtask
   // data rises while the clock is high
   task automatic stop;
      #1.3 sda_m = 1'b0;
      #40 scl_m = 1'b1;
      #40 sda_m = 1'b1;
      #80;
   endtask
endmodule
`default_nettype wire

// ---- tb/tws_slave_rx_monitor.sv ----
// port-level assertions for the two-wire slave receiver
`include "tws_map.svh"
`timescale 1ns/1ps
`default_nettype none
module tws_slave_rx_monitor (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic scl_i,
   input wire logic scl_oe_n,
   input wire logic sda_oe_n,
   input wire logic irq
);
   // ==========================================
   // helper state: data-phase tracking and control shadows
   logic ap_ff, aw_ff, ack_ff, en_ff, ien_ff; // address phase and control copies
   logic [7:0] aa_ff; // address of the pending data phase
   logic [7:0] clr_ff; // cycles since the last flag-clearing write, saturating
   logic ctl_wr; // control write completes this cycle
   assign ctl_wr = ap_ff && aw_ff && hready && aa_ff == `TWS_OFF_CTRL;
   // remember each accepted address phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ap_ff <= 1'b0;
         aw_ff <= 1'b0;
         aa_ff <= 8'h00;
      end else if (hready) begin
         ap_ff <= hsel && htrans[1];
         aw_ff <= hwrite;
         aa_ff <= haddr;
      end
   end
   // shadow of the control bits; reset matches the register reset of zero
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ack_ff <= 1'b0;
         en_ff <= 1'b0;
         ien_ff <= 1'b0;
         clr_ff <= 8'hFF;
      end else begin
         if (ctl_wr) begin
            ack_ff <= hwdata[6];
            en_ff <= hwdata[2];
            ien_ff <= hwdata[0];
         end
         if (ctl_wr && hwdata[7]) clr_ff <= 8'h00;
         else if (clr_ff != 8'hFF) clr_ff <= clr_ff + 8'h01;
      end
   end
   // ==========================================
   // assertions
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence s_rd_req;
      hsel && hready && htrans[1] && !hwrite;
   endsequence
   a_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus answer not ready or not okay");
   a_unmapped_zero: assert property (s_rd_req ##0 haddr == 8'h40 |=> hrdata == 32'h0)
      else $error("unmapped read not zero");
   a_status_format: assert property (s_rd_req ##0 haddr == `TWS_OFF_STATUS |=>
      hrdata[2:0] == 3'h0 && hrdata[31:8] == 24'h0) else $error("status low bits set");
   a_ack_enabled: assert property ($fell(sda_oe_n) |-> ack_ff && en_ff)
      else $error("acknowledge without enables");
   a_sda_scl_low: assert property ($changed(sda_oe_n) |-> !scl_i)
      else $error("data line moved while clock high");
   a_stretch_start: assert property ($fell(scl_oe_n) |-> !scl_i)
      else $error("clock hold began while clock high");
   a_stretch_release: assert property ($rose(scl_oe_n) |-> clr_ff < 8'h08)
      else $error("clock released without flag clear");
   a_irq_enable: assert property (irq |-> ien_ff || $past(ien_ff))
      else $error("irq high while disabled");
endmodule
`default_nettype wire

// ---- tb/tws_slave_rx_bench.sv ----
// self-checking bench for the two-wire slave receiver
`include "tws_map.svh"
`timescale 1ns/1ps
`default_nettype none
module tws_slave_rx_bench;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
   logic scl_o, scl_oe_n, sda_o, sda_oe_n, scl_m, sda_m, ack;
   logic [7:0] haddr, dat;
   logic [6:0] oa;
   logic [1:0] htrans;
   logic [31:0] hwdata, hrdata, rd;
   wire logic scl_w, sda_w;
   int miscompares, n_compared, seed;
   // ==========================================
   // clock and open-drain wires with pull-ups
   initial begin
      hclk = 1'b0;
      forever #2.5 hclk = ~hclk;
   end
   assign scl_w = scl_m & (scl_oe_n | scl_o);
   assign sda_w = sda_m & (sda_oe_n | sda_o);
   tws_slave_rx i_tws_slave_rx (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
      .hsize(3'b010), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
      .scl_i(scl_w), .scl_o, .scl_oe_n, .sda_i(sda_w), .sda_o, .sda_oe_n, .irq);
   tws_master_model i_tws_master_model (.scl_m, .sda_m, .scl_w, .sda_w);
   // ==========================================
   // reporting
   task automatic end_of_test;
      $display("compared %0d mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cmp_bit(input logic got, input logic exp);
      cmp_reg({31'h0, got}, {31'h0, exp});
   endtask
   // ==========================================
   // one ahb-lite single word transfer; read data lands in rd
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= a;
      i = 0;
      do begin @(posedge hclk); i++; end while (hreadyout !== 1'b1 && i < 50);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do begin @(posedge hclk); i++; end while (hreadyout !== 1'b1 && i < 50);
      rd = hrdata;
      if (i >= 50) begin cmp_bit(1'b0, 1'b1); end_of_test; end
   endtask
   // poll the flag under a bound, then the interrupt line follows it
   task automatic wait_flag;
      int j;
      for (j = 0; j < 100; j++) begin
         ahb(1'b0, `TWS_OFF_CTRL, 32'h0);
         if (rd[7] === 1'b1) break;
      end
      cmp_bit(rd[7], 1'b1);
      if (j == 100) end_of_test;
      cmp_bit(irq, 1'b1);
   endtask
   // expected codes: address phase and data phase
   function automatic logic [7:0] st_a(input logic gc, input logic arb);
      return gc ? (arb ? `TWS_ST_ARB_GC : `TWS_ST_GC) : (arb ? `TWS_ST_ARB_OWN_W : `TWS_ST_OWN_W);
   endfunction
   function automatic logic [7:0] st_d(input logic gc, input logic ak);
      return gc ? (ak ? `TWS_ST_GC_DATA_ACK : `TWS_ST_GC_DATA_NACK)
                : (ak ? `TWS_ST_OWN_DATA_ACK : `TWS_ST_OWN_DATA_NACK);
   endfunction
   // ==========================================
   // configure, address with write, one data byte if acked, stop
   task automatic run(input logic [7:0] ab, input logic gce, input logic [7:0] ctl,
      input logic arb, input logic sl, input logic ea, input logic ad);
      ahb(1'b1, `TWS_OFF_OWN_ADDR, {24'h0, oa, gce});
      ahb(1'b1, `TWS_OFF_MISC, {30'h0, arb, sl});
      ahb(1'b1, `TWS_OFF_CTRL, {24'h0, ctl});
      dat = 8'($random(seed));
      i_tws_master_model.start;
      i_tws_master_model.send(ab, ack);
      cmp_bit(ack, ea);
      if (!ea) begin
         ahb(1'b0, `TWS_OFF_CTRL, 32'h0);
         cmp_bit(rd[7], 1'b0);
      end else begin
         wait_flag;
         ahb(1'b0, `TWS_OFF_STATUS, 32'h0);
         cmp_reg(rd, {24'h0, st_a(ab[7:1] == 7'h0, arb)});
         if (sl) begin
            ahb(1'b0, `TWS_OFF_MISC, 32'h0);
            cmp_bit(rd[2], 1'b1);
         end
         ahb(1'b1, `TWS_OFF_CTRL, {24'h0, 1'b1, ad, 6'h05});
         i_tws_master_model.send(dat, ack);
         cmp_bit(ack, ad);
         wait_flag;
         ahb(1'b0, `TWS_OFF_STATUS, 32'h0);
         cmp_reg(rd, {24'h0, st_d(ab[7:1] == 7'h0, ad)});
         ahb(1'b0, `TWS_OFF_DATA, 32'h0);
         if (!sl) cmp_reg(rd, {24'h0, dat});
         ahb(1'b1, `TWS_OFF_CTRL, 32'h0000_00C5);
      end
      i_tws_master_model.stop;
      if (ea && ad) begin
         wait_flag;
         ahb(1'b0, `TWS_OFF_STATUS, 32'h0);
         cmp_reg(rd, {24'h0, `TWS_ST_STOP});
         ahb(1'b1, `TWS_OFF_CTRL, 32'h0000_00C5);
      end else if (ea) begin
         ahb(1'b0, `TWS_OFF_CTRL, 32'h0);
         cmp_bit(rd[7], 1'b0);
      end
   endtask
   // ==========================================
   // main sequence: reset values, then one frame per case
   initial begin
      seed = 26136;
      miscompares = 0;
      n_compared = 0;
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 8'h00;
      htrans = 2'b00;
      hwrite = 1'b0;
      hwdata = 32'h0;
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      ahb(1'b0, `TWS_OFF_OWN_ADDR, 32'h0);
      cmp_reg(rd, {24'h0, `TWS_RST_OWN_ADDR});
      ahb(1'b0, `TWS_OFF_CTRL, 32'h0);
      cmp_reg(rd, {24'h0, `TWS_RST_CTRL});
      ahb(1'b0, `TWS_OFF_STATUS, 32'h0);
      cmp_reg(rd, {24'h0, `TWS_RST_STATUS});
      ahb(1'b0, 8'h40, 32'h0);
      cmp_reg(rd, 32'h0);
      for (int k = 0; k < 10; k++) begin
         oa = 7'($random(seed)) | 7'h08; // never the general call address
         case (k)
            0: run({oa, 1'b0}, 1'b0, 8'h45, 1'b0, 1'b0, 1'b1, 1'b1);
            1: run({oa, 1'b0}, 1'b0, 8'h45, 1'b0, 1'b0, 1'b1, 1'b0);
            2: run(8'h00, 1'b1, 8'h45, 1'b0, 1'b0, 1'b1, 1'b1);
            3: run({oa, 1'b0}, 1'b0, 8'h45, 1'b1, 1'b0, 1'b1, 1'b1);
            4: run(8'h00, 1'b1, 8'h45, 1'b1, 1'b0, 1'b1, 1'b0);
            5: run({oa ^ 7'h01, 1'b0}, 1'b1, 8'h45, 1'b0, 1'b0, 1'b0, 1'b0);
            6: run(8'h00, 1'b0, 8'h45, 1'b0, 1'b0, 1'b0, 1'b0);
            7: run({oa, 1'b0}, 1'b0, 8'h05, 1'b0, 1'b0, 1'b0, 1'b0);
            8: run({oa, 1'b0}, 1'b0, 8'h41, 1'b0, 1'b0, 1'b0, 1'b0);
            default: run({oa, 1'b0}, 1'b1, 8'h45, 1'b0, 1'b1, 1'b1, 1'b1);
         endcase
         $display("test %0d done", k);
      end
      cmp_reg(i_tws_master_model.stalls, 32'h0);
      end_of_test;
   end
endmodule
bind tws_slave_rx tws_slave_rx_monitor i_tws_slave_rx_monitor (.hclk, .hresetn, .hsel,
   .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .scl_i,
   .scl_oe_n, .sda_oe_n, .irq);
`default_nettype wire
